/* File: src/ftr_pkg.sv */
// ftr_pkg: constants shared by the fault trip and reset manager.
// assumes a 25 MHz core clock and a plain strobe register port.
`default_nettype none
package ftr_pkg;
  // register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_WDOG   = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_FAULT  = 4'h3;
  localparam logic [3:0] ADDR_IRQST  = 4'h4;
  localparam logic [3:0] ADDR_IRQMSK = 4'h5;
  localparam logic [3:0] ADDR_LOCK   = 4'h6;
  // control register bits
  localparam int CTRL_MODBUS  = 0;
  localparam int CTRL_BACNET  = 1;
  localparam int CTRL_PLUGIN  = 2;
  localparam int CTRL_FBCTRL  = 3;
  localparam int CTRL_FRAME8  = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // watchdog register: units of milliseconds
  localparam logic [15:0] WDOG_RESET = 16'h03e8;
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_NS  = 1_000_000;
  localparam int CLK_NS = 40;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int SEC_MS = 1000;
  // lockout base time in seconds, doubled per step
  localparam int LOCK_BASE_S = 2;
  localparam int LOCK_STEPS  = 6;
  // fault numbers
  localparam logic [7:0] FLT_NONE      = 8'h00;
  localparam logic [7:0] FLT_STATOR_IMB = 8'h28;
  localparam logic [7:0] FLT_STATOR_HI = 8'h29;
  localparam logic [7:0] FLT_IND_LO    = 8'h2a;
  localparam logic [7:0] FLT_IND_HI    = 8'h2b;
  localparam logic [7:0] FLT_NONCONV   = 8'h2c;
  localparam logic [7:0] FLT_PH_ORDER  = 8'h2d;
  localparam logic [7:0] FLT_OUT_PH    = 8'h31;
  localparam logic [7:0] FLT_SERIAL    = 8'h32;
  localparam logic [7:0] FLT_PLUGIN    = 8'h34;
  localparam logic [7:0] FLT_IOMOD     = 8'h35;
  localparam logic [7:0] FLT_BACNET    = 8'h36;
  localparam logic [7:0] FLT_OVERCUR   = 8'h03;
  // interrupt status bits
  localparam int IRQ_TRIP  = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_DENY  = 2;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_LOCK = 2'b01,
    ST_TRIP = 2'b11
  } ftr_state_t;
endpackage : ftr_pkg
`default_nettype wire

/* File: src/ftr_top.sv */
// ftr_top: fault trip capture, watchdogs, reset paths and lockout timer.
// assumes inputs synchronous to CORE_CLK; power cycle is RST itself.
// no logic here: the whole block lives in ftr_core.

/* File: src/ftr_core.sv */
// ftr_core: fault trip capture, watchdogs, reset paths and lockout timer.
// assumes inputs synchronous to CORE_CLK; power cycle is RST itself.
`default_nettype none
module ftr_core #(
  parameter int unsigned CYC_MS = ftr_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // communication events
  input  wire logic        MODBUS_TELEGRAM,
  input  wire logic        BACNET_TELEGRAM,
  input  wire logic        PLUGIN_CTRL_WORD,
  input  wire logic        OPTION_COMM_LOST,
  input  wire logic        IO_MODULE_COMM_LOST,
  input  wire logic        FB_RESET_BIT,
  // power stage detections
  input  wire logic        OUTPUT_PHASE_OPEN,
  input  wire logic        SUPPLY_ORDER_BAD,
  input  wire logic        OVERCURRENT_TRIP,
  // identification results
  input  wire logic        IDENT_STATOR_IMBALANCE,
  input  wire logic        IDENT_STATOR_HIGH,
  input  wire logic        IDENT_INDUCT_LOW,
  input  wire logic        IDENT_INDUCT_HIGH,
  input  wire logic        IDENT_NONCONVERGE,
  // operator inputs
  input  wire logic        ENABLE_IN,
  input  wire logic        STOP_KEY,
  // outputs
  output logic             OUTPUT_ENABLE,
  output logic             TRIPPED,
  output logic      [7:0]  FAULT_NUM,
  output logic             IRQ
);
  localparam int unsigned SEC_CYC = CYC_MS * ftr_pkg::SEC_MS;

  ftr_pkg::ftr_state_t state_q, state_d;
  logic [7:0]  ctrl_q;
  logic [15:0] wdog_ms_q;
  logic [15:0] rdata_q;
  logic [2:0]  irq_st_q, irq_mk_q;
  logic        irq_q;
  logic [7:0]  fault_q;
  logic        oe_q;
  logic        trip_q;
  logic [2:0]  oc_count_q;
  logic [6:0]  lock_sec_q;
  logic [31:0] sec_tick_q;
  logic [31:0] ms_tick_q;
  logic [15:0] mb_ms_q, bn_ms_q, pm_ms_q;
  logic        en_prev_q, key_prev_q, fb_prev_q;
  logic        en_removed_q;

  // watchdog counter: restart on telegram, stop at limit
  function automatic logic [15:0] wd_next(input logic [15:0] cnt,
                                          input logic        kick,
                                          input logic        tick,
                                          input logic [15:0] lim);
    if (kick)
      wd_next = 16'h0000;
    else if (tick && cnt < lim)
      wd_next = cnt + 16'h0001;
    else
      wd_next = cnt;
  endfunction : wd_next

  // lockout length in seconds for a given step 1..6
  function automatic logic [6:0] lock_len(input logic [2:0] step);
    lock_len = 7'(ftr_pkg::LOCK_BASE_S << (step - 3'h1));
  endfunction : lock_len

  // decode
  wire ms_tick   = (ms_tick_q == 32'(CYC_MS - 1));
  wire sec_tick  = (sec_tick_q == 32'(SEC_CYC - 1));
  wire wr_ctrl   = WR && (ADDR == ftr_pkg::ADDR_CTRL);
  wire wr_wdog   = WR && (ADDR == ftr_pkg::ADDR_WDOG);
  wire wr_msk    = WR && (ADDR == ftr_pkg::ADDR_IRQMSK);
  wire rd_irq    = RD && (ADDR == ftr_pkg::ADDR_IRQST);
  wire wd_zero   = (wdog_ms_q == 16'h0000);
  // idle links hold their count at zero, so enabling starts a full window
  wire mb_kick = MODBUS_TELEGRAM || !ctrl_q[ftr_pkg::CTRL_MODBUS];
  wire bn_kick = BACNET_TELEGRAM || !ctrl_q[ftr_pkg::CTRL_BACNET];
  wire pm_kick = PLUGIN_CTRL_WORD || !ctrl_q[ftr_pkg::CTRL_PLUGIN];

  // watchdogs share one limit; zero disables them
  wire mb_to = ctrl_q[ftr_pkg::CTRL_MODBUS] && !wd_zero &&
               (mb_ms_q >= wdog_ms_q);
  wire bn_to = ctrl_q[ftr_pkg::CTRL_BACNET] && !wd_zero &&
               (bn_ms_q >= wdog_ms_q);
  wire pm_to = ctrl_q[ftr_pkg::CTRL_PLUGIN] && !wd_zero &&
               (pm_ms_q >= wdog_ms_q);
  wire phase_bad = SUPPLY_ORDER_BAD && ctrl_q[ftr_pkg::CTRL_FRAME8];

  // fault priority: overcurrent first, then power stage, ident, comms
  wire [7:0] new_fault =
    OVERCURRENT_TRIP       ? ftr_pkg::FLT_OVERCUR    :
    OUTPUT_PHASE_OPEN      ? ftr_pkg::FLT_OUT_PH     :
    phase_bad              ? ftr_pkg::FLT_PH_ORDER   :
    IDENT_STATOR_IMBALANCE ? ftr_pkg::FLT_STATOR_IMB :
    IDENT_STATOR_HIGH      ? ftr_pkg::FLT_STATOR_HI  :
    IDENT_INDUCT_LOW       ? ftr_pkg::FLT_IND_LO     :
    IDENT_INDUCT_HIGH      ? ftr_pkg::FLT_IND_HI     :
    IDENT_NONCONVERGE      ? ftr_pkg::FLT_NONCONV    :
    (mb_to || OPTION_COMM_LOST) ? ftr_pkg::FLT_SERIAL :
    pm_to                  ? ftr_pkg::FLT_PLUGIN     :
    IO_MODULE_COMM_LOST    ? ftr_pkg::FLT_IOMOD      :
    bn_to                  ? ftr_pkg::FLT_BACNET     :
                             ftr_pkg::FLT_NONE;
  wire trip_ev = (new_fault != ftr_pkg::FLT_NONE);

  // reset requests from the operator paths
  wire rst_en  = en_removed_q && ENABLE_IN && !en_prev_q;
  wire rst_key = STOP_KEY && !key_prev_q;
  wire rst_fb  = ctrl_q[ftr_pkg::CTRL_FBCTRL] &&
                 FB_RESET_BIT && !fb_prev_q;
  wire rst_req = rst_en || rst_key || rst_fb;
  wire lock_done = (lock_sec_q == 7'h00);
  // clearing needs only the lockout to have ended; a cause still present retrips next cycle
  wire clr_ok = rst_req && lock_done;
  wire deny   = rst_req && !lock_done && (state_q != ftr_pkg::ST_RUN);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ftr_pkg::ST_RUN: begin
        if (trip_ev)
          state_d = ftr_pkg::ST_TRIP;
      end
      ftr_pkg::ST_TRIP: begin
        if (clr_ok)
          state_d = ftr_pkg::ST_RUN;
      end
      default: begin
        state_d = ftr_pkg::ST_TRIP;
      end
    endcase
  end

  // read mux
  wire [15:0] rd_mux =
    (ADDR == ftr_pkg::ADDR_CTRL)   ? {8'h00, ctrl_q} :
    (ADDR == ftr_pkg::ADDR_WDOG)   ? wdog_ms_q :
    (ADDR == ftr_pkg::ADDR_STATUS) ? {5'h00, oc_count_q, 6'h00,
                                      oe_q, trip_q} :
    (ADDR == ftr_pkg::ADDR_FAULT)  ? {8'h00, fault_q} :
    (ADDR == ftr_pkg::ADDR_IRQST)  ? {13'h0000, irq_st_q} :
    (ADDR == ftr_pkg::ADDR_IRQMSK) ? {13'h0000, irq_mk_q} :
    (ADDR == ftr_pkg::ADDR_LOCK)   ? {9'h000, lock_sec_q} :
                                     16'h0000;
  wire [2:0] irq_ev = {deny, clr_ok && (state_q == ftr_pkg::ST_TRIP),
                       trip_ev && (state_q == ftr_pkg::ST_RUN)};
  // set wins over the read clear
  wire [2:0] irq_st_d = (rd_irq ? 3'h0 : irq_st_q) | irq_ev;

  // register file
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q    <= ftr_pkg::CTRL_RESET;
      wdog_ms_q <= ftr_pkg::WDOG_RESET;
      irq_mk_q  <= 3'h0;
      irq_st_q  <= 3'h0;
      irq_q     <= 1'b0;
      rdata_q   <= 16'h0000;
    end else begin
      if (wr_ctrl)
        ctrl_q <= WDATA[7:0];
      if (wr_wdog)
        wdog_ms_q <= WDATA;
      if (wr_msk)
        irq_mk_q <= WDATA[2:0];
      irq_st_q <= irq_st_d;
      irq_q    <= |(irq_st_d & irq_mk_q);
      rdata_q  <= RD ? rd_mux : 16'h0000;
    end
  end

  // timebases and watchdog counters
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ms_tick_q  <= 32'h0;
      sec_tick_q <= 32'h0;
      mb_ms_q    <= 16'h0000;
      bn_ms_q    <= 16'h0000;
      pm_ms_q    <= 16'h0000;
    end else begin
      ms_tick_q <= ms_tick ? 32'h0 : ms_tick_q + 32'h1;
      // second counter restarts at each trip so lockout runs from it
      if (sec_tick || (trip_ev && state_q == ftr_pkg::ST_RUN))
        sec_tick_q <= 32'h0;
      else
        sec_tick_q <= sec_tick_q + 32'h1;
      mb_ms_q <= wd_next(mb_ms_q, mb_kick, ms_tick, wdog_ms_q);
      bn_ms_q <= wd_next(bn_ms_q, bn_kick, ms_tick, wdog_ms_q);
      pm_ms_q <= wd_next(pm_ms_q, pm_kick, ms_tick, wdog_ms_q);
    end
  end

  // trip state, lockout, edge detectors
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      // power cycle clears the trip; lockout count resets with power
      state_q      <= ftr_pkg::ST_RUN;
      fault_q      <= ftr_pkg::FLT_NONE;
      trip_q       <= 1'b0;
      oe_q         <= 1'b0;
      oc_count_q   <= 3'h0;
      lock_sec_q   <= 7'h00;
      en_prev_q    <= 1'b0;
      key_prev_q   <= 1'b0;
      fb_prev_q    <= 1'b0;
      en_removed_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      en_prev_q  <= ENABLE_IN;
      key_prev_q <= STOP_KEY;
      fb_prev_q  <= FB_RESET_BIT;
      if (state_q == ftr_pkg::ST_RUN && trip_ev) begin
        fault_q      <= new_fault;
        en_removed_q <= 1'b0;
        if (new_fault == ftr_pkg::FLT_OVERCUR) begin
          if (oc_count_q != 3'(ftr_pkg::LOCK_STEPS)) begin
            oc_count_q <= oc_count_q + 3'h1;
            lock_sec_q <= lock_len(oc_count_q + 3'h1);
          end else begin
            lock_sec_q <= lock_len(oc_count_q);
          end
        end
      end else begin
        if (!ENABLE_IN && state_q == ftr_pkg::ST_TRIP)
          en_removed_q <= 1'b1;
        if (sec_tick && !lock_done)
          lock_sec_q <= lock_sec_q - 7'h01;
        if (clr_ok && state_q == ftr_pkg::ST_TRIP)
          fault_q <= ftr_pkg::FLT_NONE;
      end
      trip_q <= (state_d == ftr_pkg::ST_TRIP);
      oe_q   <= (state_d == ftr_pkg::ST_RUN) && ENABLE_IN;
    end
  end

  assign RDATA         = rdata_q;
  assign OUTPUT_ENABLE = oe_q;
  assign TRIPPED       = trip_q;
  assign FAULT_NUM     = fault_q;
  assign IRQ           = irq_q;
endmodule : ftr_core
`default_nettype wire

/* File: dv/ftr_master_model.sv */
// ftr_master_model: network master sending valid telegrams periodically.
// assumes sel chooses which link talks; sel of zero silences all.
`default_nettype none
module ftr_master_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // link choice: b0 modbus, b1 bacnet, b2 plug-in control word
  input  wire logic [2:0] sel,
  // telegram pulses
  output logic            modbus_tg,
  output logic            bacnet_tg,
  output logic            plugin_tg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  // period of 8 cycles, well inside a 2 ms watchdog
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 3'h0;
      modbus_tg <= 1'b0;
      bacnet_tg <= 1'b0;
      plugin_tg <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 3'h1;
      modbus_tg <= sel[0] && (cnt_q == 3'h0);
      bacnet_tg <= sel[1] && (cnt_q == 3'h0);
      plugin_tg <= sel[2] && (cnt_q == 3'h0);
    end
  end
endmodule : ftr_master_model
`default_nettype wire

/* File: dv/ftr_core_properties.sv */
// ftr_checker: port-level assertions for the trip and reset manager.
// assumes it is bound to ftr_core and sees only its ports.
`default_nettype none
module ftr_checker #(
  parameter int unsigned CYC_MS = 10
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        OUTPUT_PHASE_OPEN,
  input wire logic        SUPPLY_ORDER_BAD,
  input wire logic        OVERCURRENT_TRIP,
  input wire logic        IDENT_STATOR_IMBALANCE,
  input wire logic        STOP_KEY,
  input wire logic        OUTPUT_ENABLE,
  input wire logic        TRIPPED,
  input wire logic [7:0]  FAULT_NUM
);
  timeunit 1ns;
  timeprecision 1ps;
  // one ms of slack for tick alignment
  localparam int OC_MIN = 2 * 1000 * CYC_MS - CYC_MS;
  logic [31:0] oc_cnt_q;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) oc_cnt_q <= 32'h0;
    else if (TRIPPED && FAULT_NUM == 8'h03) oc_cnt_q <= oc_cnt_q + 32'h1;
    else oc_cnt_q <= 32'h0;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_trip_output_off: assert property (TRIPPED |-> !OUTPUT_ENABLE)
    else $error("output enabled while tripped");
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_fault_holds: assert property (
    TRIPPED && $past(TRIPPED) |-> $stable(FAULT_NUM))
    else $error("fault number changed during trip");
  a_fault_none: assert property (!TRIPPED |-> FAULT_NUM == 8'h00)
    else $error("fault number without trip");
  a_phase_trip: assert property (!TRIPPED && OUTPUT_PHASE_OPEN &&
    !OVERCURRENT_TRIP |=> TRIPPED && FAULT_NUM == 8'h31)
    else $error("output phase loss not tripped as 49");
  a_ident_trip: assert property (
    !TRIPPED && IDENT_STATOR_IMBALANCE &&
    !OVERCURRENT_TRIP && !OUTPUT_PHASE_OPEN && !SUPPLY_ORDER_BAD
    |=> FAULT_NUM == 8'h28)
    else $error("stator imbalance not tripped as 40");
  a_oc_trip: assert property (!TRIPPED && OVERCURRENT_TRIP
    |=> TRIPPED ##1 TRIPPED && FAULT_NUM == 8'h03)
    else $error("overcurrent trip not held");
  a_oc_lockout: assert property (
    $fell(TRIPPED) && $past(FAULT_NUM) == 8'h03
    |-> $past(oc_cnt_q) >= OC_MIN)
    else $error("overcurrent trip cleared before lockout");
  a_key_clear: assert property (TRIPPED && FAULT_NUM != 8'h03 &&
    $rose(STOP_KEY) |=> !TRIPPED)
    else $error("stop key did not clear trip");
  c_oc_cleared: cover property ($fell(TRIPPED) && $past(FAULT_NUM) == 8'h03);
endmodule : ftr_checker
bind ftr_core ftr_checker #(.CYC_MS(CYC_MS)) u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
  .OUTPUT_PHASE_OPEN(OUTPUT_PHASE_OPEN), .SUPPLY_ORDER_BAD(SUPPLY_ORDER_BAD),
  .OVERCURRENT_TRIP(OVERCURRENT_TRIP),
  .IDENT_STATOR_IMBALANCE(IDENT_STATOR_IMBALANCE), .STOP_KEY(STOP_KEY),
  .OUTPUT_ENABLE(OUTPUT_ENABLE), .TRIPPED(TRIPPED), .FAULT_NUM(FAULT_NUM));
`default_nettype wire

/* File: dv/ftr_core_tb.sv */
// ftr_core_tb: register, trip, watchdog and lockout sequences.
// assumes ftr_core with a shortened millisecond of 10 cycles.
`default_nettype none
module ftr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CM = 10;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic oc = 1'b0, fbr = 1'b0, en = 1'b1, key = 1'b0;
  logic [8:0] det = 9'h000;
  logic [2:0] sel = 3'h0;
  logic mb, bn, pg, oen, trp, irq;
  logic [7:0] fnum;
  int err_count = 0, check_count = 0;
  logic [7:0] det_code [9] = '{8'h31, 8'h2d, 8'h28, 8'h29, 8'h2a, 8'h2b,
                               8'h2c, 8'h32, 8'h35};
  logic [7:0] wd_code [3] = '{8'h32, 8'h36, 8'h34};
  always #20 clk = ~clk;
  ftr_master_model u_master (.clk(clk), .rst(rst), .sel(sel),
    .modbus_tg(mb), .bacnet_tg(bn), .plugin_tg(pg));
  ftr_core #(.CYC_MS(CM)) dut (.CORE_CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MODBUS_TELEGRAM(mb),
    .BACNET_TELEGRAM(bn), .PLUGIN_CTRL_WORD(pg), .OPTION_COMM_LOST(det[7]),
    .IO_MODULE_COMM_LOST(det[8]), .FB_RESET_BIT(fbr),
    .OUTPUT_PHASE_OPEN(det[0]), .SUPPLY_ORDER_BAD(det[1]),
    .OVERCURRENT_TRIP(oc), .IDENT_STATOR_IMBALANCE(det[2]),
    .IDENT_STATOR_HIGH(det[3]), .IDENT_INDUCT_LOW(det[4]),
    .IDENT_INDUCT_HIGH(det[5]), .IDENT_NONCONVERGE(det[6]), .ENABLE_IN(en),
    .STOP_KEY(key), .OUTPUT_ENABLE(oen), .TRIPPED(trp), .FAULT_NUM(fnum),
    .IRQ(irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_reg
  task automatic wait_trip(input int n);
    int k;
    for (k = 0; k < n && trp !== 1'b1; k++) @(posedge clk);
    #1;
    if (trp !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, trp, 1'b1);
      finish_test();
    end
  endtask : wait_trip
  // pulse one of the three operator reset paths
  task automatic do_reset(input int m);
    @(posedge clk);
    if (m == 0) key <= 1'b1;
    else if (m == 1) en <= 1'b0;
    else fbr <= 1'b1;
    @(posedge clk);
    key <= 1'b0; en <= 1'b1; fbr <= 1'b0;
    cyc(3);
  endtask : do_reset
  initial begin
    cyc(6);
    rst <= 1'b0;
    rd_reg(ftr_pkg::ADDR_CTRL, 16'h0000);
    rd_reg(ftr_pkg::ADDR_WDOG, 16'h03e8);
    rd_reg(ftr_pkg::ADDR_FAULT, 16'h0000);
    rd_reg(4'hf, 16'h0000);
    $display("test registers done");
    // frame8 plus fieldbus control, so all nine det inputs and all three reset paths apply
    wr_reg(ftr_pkg::ADDR_CTRL, 16'h0018);
    wr_reg(ftr_pkg::ADDR_IRQMSK, 16'h0001);
    rd_reg(ftr_pkg::ADDR_IRQST, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      det[i] <= 1'b1;
      wait_trip(5);
      check(fnum, det_code[i]);
      check(oen, 1'b0);
      rd_reg(ftr_pkg::ADDR_FAULT, {8'h00, det_code[i]});
      if (i == 0) begin
        check(irq, 1'b1);
        rd_reg(ftr_pkg::ADDR_IRQST, 16'h0001);
        cyc(1);
        #1 check(irq, 1'b0);
      end
      det <= 9'h000;
      do_reset(i % 3);
      check(trp, 1'b0);
      check(oen, 1'b1);
    end
    $display("test trips done");
    wr_reg(ftr_pkg::ADDR_WDOG, 16'h0002);
    for (int j = 0; j < 3; j++) begin
      sel <= 3'h1 << j;
      wr_reg(ftr_pkg::ADDR_CTRL, 16'h0001 << j);
      cyc(100);
      check(trp, 1'b0);
      sel <= 3'h0;
      wait_trip(60);
      check(fnum, wd_code[j]);
      wr_reg(ftr_pkg::ADDR_CTRL, 16'h0000);
      do_reset(0);
    end
    $display("test watchdog done");
    @(posedge clk);
    oc <= 1'b1;
    wait_trip(5);
    check(fnum, 8'h03);
    rd_reg(ftr_pkg::ADDR_LOCK, 16'h0002);
    oc <= 1'b0;
    do_reset(0);
    check(trp, 1'b1);
    cyc(2 * 1000 * CM + 2 * CM);
    do_reset(0);
    check(trp, 1'b0);
    @(posedge clk);
    oc <= 1'b1;
    wait_trip(5);
    rd_reg(ftr_pkg::ADDR_LOCK, 16'h0004);
    rd_reg(ftr_pkg::ADDR_STATUS, 16'h0201);
    oc <= 1'b0;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    check(trp, 1'b0);
    check(fnum, 8'h00);
    $display("test lockout done");
    finish_test();
  end
endmodule : ftr_core_tb
`default_nettype wire
